// *** rtl/flash_card_byte_command_decoder.sv ***
// Function
// RULE1 - Address is don't-care except program, read and sector cycles
// RULE2 - Card latches address at strobe fall; host holds it stable
// RULE3 - Card latches data at strobe rise; host holds data across it
// RULE4 - Sector erase final cycle carries sector bits 17 to 21
// RULE5 - Even segments: low select, plus bit 22 or bits 22-24 by size
// RULE6 - Odd segments: high select, plus bit 22 or bits 22-24 by size
// RULE7 - Even segment address is base plus N/2 times 400000H
// RULE8 - Odd segment address adds (N-1)/2 times 400000H plus 20000H
// RULE9 - Even byte commands: lane bit zero with low select
// RULE10 - Odd byte commands: lane bit one low select, or high select
// RULE11 - Four-cycle reset ends with a read returning the stored byte
// RULE12 - Single B0 write suspends a running sector erase
// RULE13 - Single 30 write resumes a suspended sector erase
// RULE14 - Reset is F0, or AA 55 F0 read; program AA 55 A0 data
// RULE15 - Erases AA 55 80 AA 55 10/30; identify 90 then reads 00, 02
// RULE16 - Writes only with strobe and select low, output enable high
`include "flash_cmd_map.svh"
`default_nettype none
module flash_card_byte_command_decoder
    import flash_cmd_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    input  wire logic        req_valid_i,
    output logic             req_ready_o,
    input  wire op_t         req_op_i,
    input  wire card_size_t  card_size_i,
    input  wire logic [3:0]  segment_i,
    input  wire logic        odd_lane_i,
    input  wire logic [21:0] offset_i,
    input  wire logic [7:0]  wbyte_i,
    output logic             done_o,
    output logic [7:0]       rdata_o,
    output logic [24:0]      addr_o,
    output logic [7:0]       data_o,
    output logic             data_oe_n_o,
    input  wire logic [7:0]  data_i,
    output logic             low_card_select_n_o,
    output logic             high_card_select_n_o,
    output logic             write_strobe_n_o,
    output logic             output_enable_n_o
);
    seq_reg_t r;
    seq_reg_t next_r;
    bus_cycle_if cyc ();

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Segment base: pair stride, plus odd offset for odd segments
    function automatic logic [24:0] seg_base(input logic [3:0] seg,
                                             input card_size_t sz);
        logic [24:0] b;
        logic [2:0]  pair;
        pair = seg[3:1];
        if (sz == SIZE_4MB) pair = 3'h0;
        else if (sz == SIZE_8MB) pair = {2'h0, seg[1]};  // [RULE5] [RULE6]
        b = 25'(pair) * `PAIR_STRIDE;                    // [RULE7]
        if (seg[0]) b = b + `ODD_OFFSET;                 // [RULE8]
        return b;
    endfunction : seg_base

    // Byte at a step of a command sequence
    function automatic logic [7:0] step_byte(input op_t op,
                                             input logic [2:0] s,
                                             input logic [7:0] w);
        logic [7:0] b;
        case (s)
            3'd0: b = `CMD_UNLOCK1;
            3'd1: b = `CMD_UNLOCK2;
            3'd2: b = `CMD_ERASE_SETUP;
            3'd3: b = `CMD_UNLOCK1;
            3'd4: b = `CMD_UNLOCK2;
            default: b = `CMD_SEGMENT_ERASE;
        endcase
        case (op)
            OP_RESET1: b = `CMD_RESET;                        // [RULE14]
            OP_SUSPEND: b = `CMD_SUSPEND;                     // [RULE12]
            OP_RESUME: b = `CMD_RESUME;                       // [RULE13]
            OP_RESET4: if (s == 3'd2) b = `CMD_RESET;        // [RULE14]
            OP_PROGRAM: begin
                if (s == 3'd2) b = `CMD_PROGRAM;              // [RULE14]
                if (s == 3'd3) b = w;
            end
            OP_ID_MAKER,
            OP_ID_DEVICE: if (s == 3'd2) b = `CMD_AUTOSELECT; // [RULE15]
            OP_SECT_ERASE: if (s == 3'd5) b = `CMD_SECTOR_ERASE;
            default: b = b;
        endcase
        return b;
    endfunction : step_byte

    // ----------------------------------------------------------------
    // Sequence control
    // ----------------------------------------------------------------
    logic [2:0] last_step;
    logic       final_step;
    logic       read_step;
    always_comb begin
        case (req_op_i)
            OP_RESET1, OP_SUSPEND, OP_RESUME, OP_READ: last_step = 3'd0;
            OP_SEG_ERASE, OP_SECT_ERASE: last_step = 3'd5;  // [RULE15]
            default: last_step = 3'd3;
        endcase
    end
    assign final_step = r.step == r.last;
    assign read_step  = final_step && (r.op == OP_RESET4
                        || r.op == OP_ID_MAKER || r.op == OP_ID_DEVICE
                        || r.op == OP_READ);                // [RULE11]

    // Command address: segment base, target only where it matters
    logic [24:0] cmd_addr;
    always_comb begin
        cmd_addr = r.base;                                  // [RULE1]
        if (final_step) begin
            case (r.op)
                OP_PROGRAM, OP_RESET4, OP_READ:
                    cmd_addr = r.target;                    // [RULE1]
                OP_SECT_ERASE:
                    cmd_addr = r.base | (r.target &
                        25'h03E_0000);                      // [RULE4]
                OP_ID_MAKER: cmd_addr = r.base + `ID_MAKER_OFFSET;
                OP_ID_DEVICE: cmd_addr = r.base + `ID_DEVICE_OFFSET;
                default: cmd_addr = r.base;
            endcase
        end
    end

    assign cyc.start   = r.busy && !cyc.done && !r.done;
    assign cyc.is_read = read_step;
    assign cyc.addr    = {cmd_addr[24:1], r.odd ? 1'b1 : 1'b0}; // [RULE9]
    assign cyc.data    = step_byte(r.op, r.step, r.wbyte);
    assign cyc.odd     = r.odd;                             // [RULE10]

    always_comb begin
        next_r      = r;
        next_r.done = 1'b0;
        if (!r.busy) begin
            if (req_valid_i) begin
                next_r.busy   = 1'b1;
                next_r.step   = 3'd0;
                next_r.last   = last_step;
                next_r.op     = req_op_i;
                next_r.base   = seg_base(segment_i, card_size_i);
                next_r.target = seg_base(segment_i, card_size_i)
                                + {3'h0, offset_i};
                next_r.wbyte  = wbyte_i;
                next_r.odd    = segment_i[0] | odd_lane_i; // [RULE6]
            end
        end else if (cyc.done) begin
            if (read_step) next_r.rdata = cyc.rdata;       // [RULE11]
            if (final_step) begin
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
            end else begin
                next_r.step = r.step + 3'd1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            r <= '{op: OP_RESET1, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign req_ready_o = !r.busy;
    assign done_o      = r.done;
    assign rdata_o     = r.rdata;

    // ----------------------------------------------------------------
    // Pin cycle engine
    // ----------------------------------------------------------------
    card_bus_cycle u_cycle (
        .clk_sys_i            (clk_sys_i),
        .sys_rst_i            (sys_rst_i),
        .cyc                  (cyc),
        .addr_o               (addr_o),
        .data_o               (data_o),
        .data_oe_n_o          (data_oe_n_o),
        .data_i               (data_i),
        .low_card_select_n_o  (low_card_select_n_o),
        .high_card_select_n_o (high_card_select_n_o),
        .write_strobe_n_o     (write_strobe_n_o),
        .output_enable_n_o    (output_enable_n_o)
    );
endmodule : flash_card_byte_command_decoder
`default_nettype wire

// *** rtl/flash_cmd_map.svh ***
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH

// ----------------------------------------------------------------
// Command bytes
// ----------------------------------------------------------------
`define CMD_UNLOCK1       8'hAA
`define CMD_UNLOCK2       8'h55
`define CMD_RESET         8'hF0
`define CMD_PROGRAM       8'hA0
`define CMD_ERASE_SETUP   8'h80
`define CMD_SEGMENT_ERASE 8'h10
`define CMD_SECTOR_ERASE  8'h30
`define CMD_RESUME        8'h30
`define CMD_SUSPEND       8'hB0
`define CMD_AUTOSELECT    8'h90

// ----------------------------------------------------------------
// Address layout
// ----------------------------------------------------------------
`define PAIR_STRIDE       25'h040_0000
`define ODD_OFFSET        25'h002_0000
`define SECTOR_LSB        17
`define SECTOR_MSB        21
`define ID_MAKER_OFFSET   25'h000_0000
`define ID_DEVICE_OFFSET  25'h000_0002

// ----------------------------------------------------------------
// Pin timing, in nanoseconds, rounded up to clock cycles
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     40
`define SETUP_NS          80
`define STROBE_NS         120
`define HOLD_NS           80
`define READ_NS           160
`define SETUP_CYC  ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYC ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYC   ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYC   ((`READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** rtl/flash_cmd_pkg.sv ***
`default_nettype none
package flash_cmd_pkg;
    typedef enum logic [3:0] {
        OP_RESET1     = 4'h0,
        OP_RESET4     = 4'h1,
        OP_PROGRAM    = 4'h2,
        OP_SEG_ERASE  = 4'h3,
        OP_SECT_ERASE = 4'h4,
        OP_SUSPEND    = 4'h5,
        OP_RESUME     = 4'h6,
        OP_ID_MAKER   = 4'h7,
        OP_ID_DEVICE  = 4'h8,
        OP_READ       = 4'h9
    } op_t;

    typedef enum logic [1:0] {
        SIZE_4MB  = 2'h0,
        SIZE_8MB  = 2'h1,
        SIZE_20MB = 2'h2,
        SIZE_32MB = 2'h3
    } card_size_t;

    typedef enum logic [4:0] {
        CYC_IDLE   = 5'b0_0001,
        CYC_SETUP  = 5'b0_0010,
        CYC_STROBE = 5'b0_0100,
        CYC_HOLD   = 5'b0_1000,
        CYC_READ   = 5'b1_0000
    } cyc_state_t;

    typedef struct packed {
        cyc_state_t  state;
        logic [3:0]  count;
        logic [24:0] addr;
        logic [7:0]  data;
        logic        lane;
        logic        odd;
        logic        is_read;
        logic [7:0]  rdata;
        logic        done;
    } cyc_reg_t;

    typedef struct packed {
        logic        busy;
        logic [2:0]  step;
        logic [2:0]  last;
        op_t         op;
        logic [24:0] base;
        logic [24:0] target;
        logic [7:0]  wbyte;
        logic        odd;
        logic [7:0]  rdata;
        logic        done;
    } seq_reg_t;
endpackage : flash_cmd_pkg
`default_nettype wire

// *** rtl/bus_cycle_if.sv ***
`default_nettype none
interface bus_cycle_if;
    logic        start;
    logic        is_read;
    logic [24:0] addr;
    logic [7:0]  data;
    logic        odd;
    logic        done;
    logic [7:0]  rdata;
    modport seq (output start, is_read, addr, data, odd,
                 input done, rdata);
    modport pins (input start, is_read, addr, data, odd,
                  output done, rdata);
endinterface : bus_cycle_if
`default_nettype wire

// *** rtl/card_bus_cycle.sv ***
`include "flash_cmd_map.svh"
`default_nettype none
module card_bus_cycle
    import flash_cmd_pkg::*;
(
    input  wire logic   clk_sys_i,
    input  wire logic   sys_rst_i,
    bus_cycle_if.pins   cyc,
    output logic [24:0] addr_o,
    output logic [7:0]  data_o,
    output logic        data_oe_n_o,
    input  wire logic [7:0] data_i,
    output logic        low_card_select_n_o,
    output logic        high_card_select_n_o,
    output logic        write_strobe_n_o,
    output logic        output_enable_n_o
);
    cyc_reg_t r;
    cyc_reg_t next_r;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sync3;

    // ----------------------------------------------------------------
    // Read data synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        sync1 <= data_i;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    // Strobe sequencer: address set up before the falling edge
    always_comb begin
        next_r      = r;
        next_r.done = 1'b0;
        case (r.state)
            CYC_IDLE: begin
                if (cyc.start) begin
                    next_r.state   = CYC_SETUP;
                    next_r.count   = 4'(`SETUP_CYC);
                    next_r.addr    = cyc.addr;
                    next_r.data    = cyc.data;
                    next_r.lane    = cyc.addr[0];
                    next_r.odd     = cyc.odd;
                    next_r.is_read = cyc.is_read;
                end
            end
            CYC_SETUP: begin
                if (r.count == 4'h1) begin
                    next_r.state = r.is_read ? CYC_READ : CYC_STROBE;
                    next_r.count = r.is_read ? 4'(`READ_CYC)
                                             : 4'(`STROBE_CYC);
                end else begin
                    next_r.count = r.count - 4'h1;
                end
            end
            CYC_STROBE: begin
                if (r.count == 4'h1) begin
                    next_r.state = CYC_HOLD;
                    next_r.count = 4'(`HOLD_CYC);
                end else begin
                    next_r.count = r.count - 4'h1;
                end
            end
            CYC_READ: begin
                if (r.count == 4'h1 && sync2 == sync3) begin
                    next_r.rdata = sync3;
                    next_r.state = CYC_HOLD;
                    next_r.count = 4'(`HOLD_CYC);
                end else if (r.count != 4'h1) begin
                    next_r.count = r.count - 4'h1;
                end
            end
            CYC_HOLD: begin
                if (r.count == 4'h1) begin
                    next_r.state = CYC_IDLE;
                    next_r.done  = 1'b1;
                end else begin
                    next_r.count = r.count - 4'h1;
                end
            end
            default: next_r.state = CYC_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            r <= '{state: CYC_IDLE, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    logic active;
    assign active = r.state != CYC_IDLE;
    // Odd lane: high select; even lane: low select with lane bit 0
    assign high_card_select_n_o = !(active && r.odd);         // [RULE10]
    assign low_card_select_n_o  = !(active && !r.odd);        // [RULE9]
    // Address falls with strobe, data rises with it
    assign write_strobe_n_o  = !(r.state == CYC_STROBE);      // [RULE2]
    assign output_enable_n_o = !(r.state == CYC_READ);        // [RULE16]
    assign addr_o      = {r.addr[24:1], r.lane};
    assign data_o      = r.data;                              // [RULE3]
    assign data_oe_n_o = !(active && !r.is_read);
    assign cyc.done    = r.done;
    assign cyc.rdata   = r.rdata;
endmodule : card_bus_cycle
`default_nettype wire

// *** test/card_model.sv ***
`default_nettype none
module card_model
    import flash_cmd_pkg::*;
#(
    parameter logic [7:0] ID_MAKER  = 8'h5C, // Arbitrary value
    parameter logic [7:0] ID_DEVICE = 8'hA7  // Arbitrary value
) (
    input  wire logic        clk_i,
    input  wire logic [24:0] addr_i,
    input  wire logic [7:0]  data_i,
    input  wire logic        low_card_select_n_i,
    input  wire logic        high_card_select_n_i,
    input  wire logic        write_strobe_n_i,
    input  wire logic        output_enable_n_i,
    output logic [7:0]       data_o
);
    // ------------------------------------------------------------
    // Card command latch and byte array
    // ------------------------------------------------------------
    logic [7:0]  mem [logic [24:0]];
    logic [24:0] addr_lat;
    logic [24:0] last_addr;
    logic [7:0]  last_data;
    logic [31:0] hist;
    logic [7:0]  noise;
    logic [7:0]  rd_val;
    logic        last_hi;
    logic        id_mode;
    logic        erasing;
    logic        suspended;
    int          n_wr;
    wire         sel = !low_card_select_n_i || !high_card_select_n_i;

    initial begin
        {n_wr, hist, id_mode, erasing, suspended, noise} = '0;
    end

    // Address taken at strobe fall of an enabled write
    always @(negedge write_strobe_n_i) begin
        if (sel && output_enable_n_i) addr_lat = addr_i;
    end

    // Data taken at strobe rise decides the command
    always @(posedge write_strobe_n_i) begin
        if (sel && output_enable_n_i) begin
            n_wr++;
            last_addr = addr_lat;
            last_data = data_i;
            last_hi   = !high_card_select_n_i;
            if (hist[23:0] == 24'hAA_55A0) mem[addr_lat] = data_i;
            else if (data_i == 8'hF0) id_mode = 1'b0;
            else if (data_i == 8'h90) id_mode = 1'b1;
            else if (data_i == 8'h30 && hist == 32'h5580_AA55)
                erasing = 1'b1;
            else if (data_i == 8'hB0 && erasing) suspended = 1'b1;
            else if (data_i == 8'h30 && suspended)
                suspended = 1'b0;
            hist = {hist[23:0], data_i};
        end
    end

    // Undriven bus holds the inverse of the last addressed byte
    always @(posedge clk_i) noise <= ~rd_val;
    always_comb begin
        if (id_mode) rd_val = addr_i[1] ? ID_DEVICE : ID_MAKER;
        else if (mem.exists(addr_i)) rd_val = mem[addr_i];
        else rd_val = 8'hFF;
        data_o = (sel && !output_enable_n_i) ? rd_val : noise;
    end
endmodule : card_model
`default_nettype wire

// *** test/flash_cmd_props.sv ***
`default_nettype none
module flash_cmd_props (
    input wire logic        clk_sys_i,
    input wire logic        sys_rst_i,
    input wire logic        req_valid_i,
    input wire logic        req_ready_o,
    input wire logic        done_o,
    input wire logic [24:0] addr_o,
    input wire logic [7:0]  data_o,
    input wire logic        data_oe_n_o,
    input wire logic        low_card_select_n_o,
    input wire logic        high_card_select_n_o,
    input wire logic        write_strobe_n_o,
    input wire logic        output_enable_n_o
);
    // ------------------------------------------------------------
    // Pin sequencing checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    wire sel_any = !(low_card_select_n_o && high_card_select_n_o);

    property p_we_qual;
        !write_strobe_n_o |-> sel_any && output_enable_n_o;
    endproperty
    a_we_qual: assert property (p_we_qual)
        else $error("strobe low without select or with output enable");
    property p_addr_stable;
        !write_strobe_n_o |-> $stable(addr_o);
    endproperty
    a_addr_stable: assert property (p_addr_stable)
        else $error("address moved while strobe low");
    property p_setup;
        $fell(write_strobe_n_o) |-> $past(sel_any, 2);
    endproperty
    a_setup: assert property (p_setup)
        else $error("select not set up before strobe fall");
    property p_width;
        $fell(write_strobe_n_o) |->
            !write_strobe_n_o [*3] ##1 write_strobe_n_o;
    endproperty
    a_width: assert property (p_width)
        else $error("strobe pulse width wrong");
    property p_data_rise;
        $rose(write_strobe_n_o) |-> $stable(data_o) && !data_oe_n_o;
    endproperty
    a_data_rise: assert property (p_data_rise)
        else $error("write data not held at strobe rise");
    property p_hold;
        $rose(write_strobe_n_o) |-> sel_any ##1 sel_any;
    endproperty
    a_hold: assert property (p_hold)
        else $error("select released too early");
    property p_one_sel;
        !(!low_card_select_n_o && !high_card_select_n_o);
    endproperty
    a_one_sel: assert property (p_one_sel)
        else $error("both selects low in byte mode");
    property p_no_fight;
        !output_enable_n_o |-> data_oe_n_o && write_strobe_n_o;
    endproperty
    a_no_fight: assert property (p_no_fight)
        else $error("host drives data during read");
    property p_take;
        req_valid_i && req_ready_o |=> !req_ready_o;
    endproperty
    a_take: assert property (p_take)
        else $error("ready stayed high after a request");
    property p_done;
        done_o |-> write_strobe_n_o && output_enable_n_o ##1 !done_o;
    endproperty
    a_done: assert property (p_done)
        else $error("done not a single pulse on idle pins");

    c_odd_write: cover property ($rose(write_strobe_n_o)
                                 && !high_card_select_n_o);
    c_read: cover property (!output_enable_n_o);
    c_done: cover property (done_o);
endmodule : flash_cmd_props

bind flash_card_byte_command_decoder flash_cmd_props flash_cmd_props_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i),
    .req_ready_o(req_ready_o), .done_o(done_o), .addr_o(addr_o),
    .data_o(data_o), .data_oe_n_o(data_oe_n_o),
    .low_card_select_n_o(low_card_select_n_o),
    .high_card_select_n_o(high_card_select_n_o),
    .write_strobe_n_o(write_strobe_n_o),
    .output_enable_n_o(output_enable_n_o));
`default_nettype wire

// *** test/tb.sv ***
`default_nettype none
module tb
    import flash_cmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Stimulus and checking
    // ------------------------------------------------------------
    logic        clk_sys_i   = 1'b0;
    logic        sys_rst_i   = 1'b1;
    logic        req_valid_i = 1'b0;
    logic        req_ready_o;
    op_t         req_op_i    = OP_RESET1;
    card_size_t  card_size_i = SIZE_32MB;
    logic [3:0]  segment_i   = 4'h0;
    logic        odd_lane_i  = 1'b0;
    logic [21:0] offset_i    = 22'h00_0000;
    logic [7:0]  wbyte_i     = 8'h00;
    logic        done_o;
    logic [7:0]  rdata_o;
    logic [24:0] addr_o;
    logic [7:0]  data_o;
    logic        data_oe_n_o;
    logic [7:0]  card_data;
    logic        low_card_select_n_o;
    logic        high_card_select_n_o;
    logic        write_strobe_n_o;
    logic        output_enable_n_o;
    int          n_mismatch  = 0;
    int          cmp_count   = 0;
    int          n0;

    // Free running system clock
    always #20 clk_sys_i = ~clk_sys_i;

    flash_card_byte_command_decoder flash_card_byte_command_decoder_inst (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
        .req_op_i(req_op_i), .card_size_i(card_size_i),
        .segment_i(segment_i), .odd_lane_i(odd_lane_i),
        .offset_i(offset_i), .wbyte_i(wbyte_i), .done_o(done_o),
        .rdata_o(rdata_o), .addr_o(addr_o), .data_o(data_o),
        .data_oe_n_o(data_oe_n_o), .data_i(card_data),
        .low_card_select_n_o(low_card_select_n_o),
        .high_card_select_n_o(high_card_select_n_o),
        .write_strobe_n_o(write_strobe_n_o),
        .output_enable_n_o(output_enable_n_o));

    card_model card_model_inst (
        .clk_i(clk_sys_i), .addr_i(addr_o), .data_i(data_o),
        .low_card_select_n_i(low_card_select_n_o),
        .high_card_select_n_i(high_card_select_n_o),
        .write_strobe_n_i(write_strobe_n_o),
        .output_enable_n_i(output_enable_n_o), .data_o(card_data));

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One operation through the request port, bounded wait for done
    task run_op(input op_t op, input card_size_t sz, input logic [3:0] seg,
                input logic [21:0] off, input logic [7:0] wb);
        n0 = card_model_inst.n_wr;
        @(negedge clk_sys_i);
        {req_op_i, card_size_i, segment_i, offset_i} = {op, sz, seg, off};
        wbyte_i     = wb;
        req_valid_i = 1'b1;
        @(negedge clk_sys_i);
        req_valid_i = 1'b0;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk_sys_i);
            #1;
            if (done_o === 1'b1) return;
        end
        n_mismatch++;
        tally_and_finish();
    endtask : run_op

    task expect_wr(input int n, input logic [7:0] d, input logic hi);
        chk(card_model_inst.n_wr - n0, n);
        chk({24'h00_0000, card_model_inst.last_data}, {24'h00_0000, d});
        chk({31'h0000_0000, card_model_inst.last_hi}, {31'h0000_0000, hi});
    endtask : expect_wr

    task sc_program_read;
        run_op(OP_PROGRAM, SIZE_8MB, 4'h3, 22'h00_1234, 8'h5A);
        expect_wr(4, 8'h5A, 1'b1);
        chk(card_model_inst.last_addr, 25'h042_1235);
        run_op(OP_READ, SIZE_32MB, 4'h3, 22'h00_1234, 8'h00);
        chk(card_model_inst.n_wr - n0, 0);
        chk(rdata_o, 8'h5A);
        run_op(OP_RESET4, SIZE_32MB, 4'h3, 22'h00_1234, 8'h00);
        expect_wr(3, 8'hF0, 1'b1);
        chk(rdata_o, 8'h5A);
    endtask : sc_program_read

    task sc_sector_suspend;
        run_op(OP_SECT_ERASE, SIZE_32MB, 4'h4, 22'h0A_0000, 8'h00);
        expect_wr(6, 8'h30, 1'b0);
        chk(card_model_inst.last_addr, 25'h08A_0000);
        run_op(OP_SUSPEND, SIZE_32MB, 4'h4, 22'h00_0000, 8'h00);
        expect_wr(1, 8'hB0, 1'b0);
        chk(card_model_inst.suspended, 1'b1);
        run_op(OP_RESUME, SIZE_32MB, 4'h4, 22'h00_0000, 8'h00);
        expect_wr(1, 8'h30, 1'b0);
        chk(card_model_inst.suspended, 1'b0);
    endtask : sc_sector_suspend

    task sc_erase_reset_id;
        run_op(OP_SEG_ERASE, SIZE_32MB, 4'h0, 22'h00_0000, 8'h00);
        expect_wr(6, 8'h10, 1'b0);
        run_op(OP_ID_MAKER, SIZE_32MB, 4'h1, 22'h00_0000, 8'h00);
        chk(card_model_inst.last_data, 8'h90);
        chk(rdata_o, card_model_inst.ID_MAKER);
        run_op(OP_ID_DEVICE, SIZE_32MB, 4'h1, 22'h00_0000, 8'h00);
        chk(rdata_o, card_model_inst.ID_DEVICE);
        run_op(OP_RESET1, SIZE_32MB, 4'h1, 22'h00_0000, 8'h00);
        expect_wr(1, 8'hF0, 1'b1);
        // Odd lane of an even segment on the smallest card
        @(negedge clk_sys_i);
        odd_lane_i = 1'b1;
        run_op(OP_RESET1, SIZE_4MB, 4'h0, 22'h00_0000, 8'h00);
        expect_wr(1, 8'hF0, 1'b1);
        chk(card_model_inst.last_addr, 25'h000_0001);
        @(negedge clk_sys_i);
        odd_lane_i = 1'b0;
        // Top odd segment of the 20 Mbyte card
        run_op(OP_RESET1, SIZE_20MB, 4'h9, 22'h00_0000, 8'h00);
        chk(card_model_inst.last_addr, 25'h102_0001);
    endtask : sc_erase_reset_id

    // Main sequence
    initial begin
        repeat (6) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        chk({low_card_select_n_o, high_card_select_n_o, write_strobe_n_o,
             output_enable_n_o, data_oe_n_o, req_ready_o}, 6'h3F);
        sc_program_read();
        sc_sector_suspend();
        sc_erase_reset_id();
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
